// ### hw/sttc_pkg.sv
package sttc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_TICK_COUNTER = 8'h00;
    localparam logic [7:0] ADDR_SUMMARY_STATUS = 8'h01;
    localparam logic [7:0] ADDR_SUPPLY_STATUS = 8'h02;
    localparam logic [7:0] ADDR_MEMORY_TEMP_STATUS = 8'h03;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ------------------------------------------------------------
    // Summary status fields
    // ------------------------------------------------------------
    localparam int SUM_DSP_ERROR_BIT = 7;
    localparam int SUM_COMMUNICATION_ERROR_BIT = 5;
    localparam int SUM_MEMORY_TEMP_ERROR_BIT = 4;
    localparam int SUM_SUPPLY_ERROR_BIT = 3;
    localparam int SUM_TEST_ACTIVE_BIT = 2;
    localparam int SUM_RESET_OCCURRED_BIT = 1;
    localparam int SUM_INIT_IN_PROGRESS_BIT = 0;

    // ------------------------------------------------------------
    // Supply status fields
    // ------------------------------------------------------------
    localparam int SUP_UNDERVOLTAGE_BIT = 7;
    localparam int SUP_ANALOG_REG_BIT = 3;
    localparam int SUP_DIGITAL_REG_BIT = 2;
    localparam int SUP_NVM_REG_BIT = 1;
    localparam int SUP_CONTINUITY_BIT = 0;

    // ------------------------------------------------------------
    // Memory and temperature status fields
    // ------------------------------------------------------------
    localparam int MT_FACTORY_NVM_BIT = 7;
    localparam int MT_USER_NVM_BIT = 6;
    localparam int MT_USER_REG_CHECK_BIT = 5;
    localparam int MT_USER_PROG_ACTIVE_BIT = 4;
    localparam int MT_TEMPERATURE_BIT = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] TICK_RESET = 8'h00;
    localparam logic [4:0] SUPPLY_RESET = 5'h00;
    localparam logic [3:0] MEMTEMP_RESET = 4'h0;
    localparam logic TEST_ACTIVE_RESET = 1'b0;
    localparam logic RESET_OCCURRED_RESET = 1'b1;
    localparam logic INIT_IN_PROGRESS_RESET = 1'b1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_PERIOD_US = 100;
    localparam int PRESCALE_W = 10;
    localparam int TICK_W = 8;
    localparam int PRESCALE_DIV = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;
    localparam int SUPPLY_RECOVERY_INTERVAL_US = 1000;
    localparam int SUPPLY_RECOVERY_CYCLES = (SUPPLY_RECOVERY_INTERVAL_US * 1000) / CLK_PERIOD_NS;

endpackage : sttc_pkg

// ### hw/sttc_recovery_timer.sv
`timescale 1ns/10ps
module sttc_recovery_timer #(
    parameter int CYCLES = 10000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_rst,
    input wire logic error_present,
    output logic quiet_ff
);

    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LOAD = W'(CYCLES);

    logic [W-1:0] remain_ff;
    logic [W-1:0] nxt_remain;

    // ------------------------------------------------------------
    // Reload while any error, else count down to zero
    // ------------------------------------------------------------
    always_comb begin
        nxt_remain = remain_ff;
        if (soft_rst) begin
            nxt_remain = '0;
        end else if (error_present) begin
            nxt_remain = LOAD;
        end else if (remain_ff != '0) begin
            nxt_remain = remain_ff - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            remain_ff <= '0;
        end else begin
            remain_ff <= nxt_remain;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            quiet_ff <= 1'b1;
        end else begin
            quiet_ff <= (nxt_remain == '0);
        end
    end

endmodule : sttc_recovery_timer

// ### hw/sttc_status_regs.sv
// Notes on behaviour
// - Tick counter register is read-only, 8 bits, free-running; writes do nothing.
// - Prescaler divides oscillator by 1000; tick every 100 us, wrap every 25.6 ms.
// - Host cannot load or clear the tick counter.
// - All status registers are read-only and readable through the single host read port.
// - Summary bit 7 is OR of self-test incomplete, common-mode and self-test errors.
// - Summary bit 5 follows the link readback mismatch flag.
// - Summary bit 4 is OR of the five memory and temperature bits.
// - Summary bit 3 is OR of all supply and continuity error bits.
// - Summary bit 2 shows test mode; cleared only by test operation or power cycle.
// - Summary bit 1 set by reset; cleared by summary read or status report.
// - Summary bit 0 set by reset; cleared once sensor data first becomes valid.
// - Supply bit 7 set on supply undervoltage.
// - Supply bit 3 set on analog regulator out of range.
// - Supply bit 2 set on digital regulator out of range.
// - Supply bit 1 set on nonvolatile regulator out of range.
// - Supply bit 0 set on edge seal continuity break; resets to zero.
// - One recovery timer for supply bits, reloaded while any error; disable steers clearing.
// - Memory and temperature error bits clear on their register read or status report.
// - User programming active bit follows an ongoing user nonvolatile write.
`timescale 1ns/10ps
module sttc_status_regs #(
    parameter int SUPPLY_RECOVERY_CYCLES = sttc_pkg::SUPPLY_RECOVERY_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_rst,
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    input wire logic status_reported,
    input wire logic selftest_incomplete,
    input wire logic common_mode_error,
    input wire logic selftest_error,
    input wire logic communication_error,
    input wire logic factory_nvm_error_evt,
    input wire logic user_nvm_error_evt,
    input wire logic user_reg_check_error_evt,
    input wire logic temperature_error_evt,
    input wire logic user_prog_active,
    input wire logic test_enter,
    input wire logic test_exit,
    input wire logic data_valid,
    input wire logic supply_undervoltage_mon,
    input wire logic analog_regulator_mon,
    input wire logic digital_regulator_mon,
    input wire logic nvm_regulator_mon,
    input wire logic continuity_mon,
    input wire logic supply_report_disable,
    output logic [7:0] rd_data_ff,
    output logic [7:0] summary_status_ff
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [sttc_pkg::TICK_W-1:0] tick_count;
    logic supply_quiet;
    logic [4:0] supply_mon;
    logic [4:0] supply_err_ff;
    logic [4:0] nxt_supply_err;
    logic [3:0] memtemp_evt;
    logic [3:0] memory_temp_error_ff;
    logic [3:0] nxt_memory_temp_error;
    logic user_prog_active_ff;
    logic test_active_ff;
    logic reset_occurred_ff;
    logic init_in_progress_ff;
    logic rd_summary;
    logic rd_memtemp;
    logic any_supply_mon;
    logic dsp_error;
    logic memtemp_error;
    logic supply_error;
    logic [7:0] summary_status;
    logic [7:0] supply_status;
    logic [7:0] memory_temp_status;
    logic [7:0] nxt_rd_data;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] place_bit(input int pos, input logic val);
        logic [7:0] word;
        word = 8'h00;
        word[pos] = val;
        return word;
    endfunction : place_bit

    function automatic logic is_read(input logic en, input logic [7:0] addr, input logic [7:0] target);
        return en && (addr == target);
    endfunction : is_read

    assign rd_summary = is_read(rd_en, rd_addr, sttc_pkg::ADDR_SUMMARY_STATUS);
    assign rd_memtemp = is_read(rd_en, rd_addr, sttc_pkg::ADDR_MEMORY_TEMP_STATUS);

    // ------------------------------------------------------------
    // Tick counter
    // ------------------------------------------------------------
    // No host write path, so only a reset can load or clear the count
    sttc_tick_counter #(
        .PRESCALE_W(sttc_pkg::PRESCALE_W),
        .TICK_W(sttc_pkg::TICK_W),
        .PRESCALE_DIV(sttc_pkg::PRESCALE_DIV)
    ) u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .soft_rst(soft_rst),
        .count_ff(tick_count)
    );

    // ------------------------------------------------------------
    // Supply status
    // ------------------------------------------------------------
    assign supply_mon = {supply_undervoltage_mon, analog_regulator_mon, digital_regulator_mon,
                         nvm_regulator_mon, continuity_mon};
    assign any_supply_mon = |supply_mon;

    sttc_recovery_timer #(
        .CYCLES(SUPPLY_RECOVERY_CYCLES)
    ) u_recovery (
        .clk(clk),
        .rst_n(rst_n),
        .soft_rst(soft_rst),
        .error_present(any_supply_mon),
        .quiet_ff(supply_quiet)
    );

    // Bits hold until the shared timer has run out; disable clears them and blocks new sets
    always_comb begin
        nxt_supply_err = supply_err_ff;
        if (supply_report_disable) begin
            nxt_supply_err = '0;
        end else begin
            if (supply_quiet) begin
                nxt_supply_err = '0;
            end
            nxt_supply_err = nxt_supply_err | supply_mon;
        end
        if (soft_rst) begin
            nxt_supply_err = sttc_pkg::SUPPLY_RESET;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            supply_err_ff <= sttc_pkg::SUPPLY_RESET;
        end else begin
            supply_err_ff <= nxt_supply_err;
        end
    end

    assign supply_status = place_bit(sttc_pkg::SUP_UNDERVOLTAGE_BIT, supply_err_ff[4])
                         | place_bit(sttc_pkg::SUP_ANALOG_REG_BIT, supply_err_ff[3])
                         | place_bit(sttc_pkg::SUP_DIGITAL_REG_BIT, supply_err_ff[2])
                         | place_bit(sttc_pkg::SUP_NVM_REG_BIT, supply_err_ff[1])
                         | place_bit(sttc_pkg::SUP_CONTINUITY_BIT, supply_err_ff[0]);

    // ------------------------------------------------------------
    // Memory and temperature status
    // ------------------------------------------------------------
    assign memtemp_evt = {factory_nvm_error_evt, user_nvm_error_evt, user_reg_check_error_evt,
                          temperature_error_evt};

    // Sticky; a new event wins over a clear in the same cycle
    always_comb begin
        nxt_memory_temp_error = memory_temp_error_ff;
        if (rd_memtemp || status_reported) begin
            nxt_memory_temp_error = '0;
        end
        nxt_memory_temp_error = nxt_memory_temp_error | memtemp_evt;
        if (soft_rst) begin
            nxt_memory_temp_error = sttc_pkg::MEMTEMP_RESET;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            memory_temp_error_ff <= sttc_pkg::MEMTEMP_RESET;
        end else begin
            memory_temp_error_ff <= nxt_memory_temp_error;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            user_prog_active_ff <= 1'b0;
        end else begin
            user_prog_active_ff <= user_prog_active && !soft_rst;
        end
    end

    assign memory_temp_status = place_bit(sttc_pkg::MT_FACTORY_NVM_BIT, memory_temp_error_ff[3])
                              | place_bit(sttc_pkg::MT_USER_NVM_BIT, memory_temp_error_ff[2])
                              | place_bit(sttc_pkg::MT_USER_REG_CHECK_BIT, memory_temp_error_ff[1])
                              | place_bit(sttc_pkg::MT_USER_PROG_ACTIVE_BIT, user_prog_active_ff)
                              | place_bit(sttc_pkg::MT_TEMPERATURE_BIT, memory_temp_error_ff[0]);

    // ------------------------------------------------------------
    // Test mode flag, survives soft reset
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            test_active_ff <= sttc_pkg::TEST_ACTIVE_RESET;
        end else if (test_enter) begin
            test_active_ff <= 1'b1;
        end else if (test_exit) begin
            test_active_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Reset occurred flag
    // ------------------------------------------------------------
    // Soft reset wins over a read clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_occurred_ff <= sttc_pkg::RESET_OCCURRED_RESET;
        end else if (soft_rst) begin
            reset_occurred_ff <= 1'b1;
        end else if (rd_summary || status_reported) begin
            reset_occurred_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Initialisation flag
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            init_in_progress_ff <= sttc_pkg::INIT_IN_PROGRESS_RESET;
        end else if (soft_rst) begin
            init_in_progress_ff <= 1'b1;
        end else if (data_valid) begin
            init_in_progress_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Aggregate error flags
    // ------------------------------------------------------------
    // Live ORs with no latch, so each clears with its last source
    assign dsp_error = selftest_incomplete | common_mode_error | selftest_error;
    assign memtemp_error = |memory_temp_status;
    assign supply_error = |supply_status;

    // ------------------------------------------------------------
    // Summary status, aggregates from current bits
    // ------------------------------------------------------------
    assign summary_status =
        place_bit(sttc_pkg::SUM_DSP_ERROR_BIT, dsp_error)
      | place_bit(sttc_pkg::SUM_COMMUNICATION_ERROR_BIT, communication_error)
      | place_bit(sttc_pkg::SUM_MEMORY_TEMP_ERROR_BIT, memtemp_error)
      | place_bit(sttc_pkg::SUM_SUPPLY_ERROR_BIT, supply_error)
      | place_bit(sttc_pkg::SUM_TEST_ACTIVE_BIT, test_active_ff)
      | place_bit(sttc_pkg::SUM_RESET_OCCURRED_BIT, reset_occurred_ff)
      | place_bit(sttc_pkg::SUM_INIT_IN_PROGRESS_BIT, init_in_progress_ff);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            summary_status_ff <= 8'h00;
        end else begin
            summary_status_ff <= summary_status;
        end
    end

    // ------------------------------------------------------------
    // Read port, values captured before any read clear
    // ------------------------------------------------------------
    always_comb begin
        nxt_rd_data = rd_data_ff;
        if (rd_en) begin
            case (rd_addr)
                sttc_pkg::ADDR_TICK_COUNTER: begin
                    nxt_rd_data = tick_count;
                end
                sttc_pkg::ADDR_SUMMARY_STATUS: begin
                    nxt_rd_data = summary_status;
                end
                sttc_pkg::ADDR_SUPPLY_STATUS: begin
                    nxt_rd_data = supply_status;
                end
                sttc_pkg::ADDR_MEMORY_TEMP_STATUS: begin
                    nxt_rd_data = memory_temp_status;
                end
                default: begin
                    nxt_rd_data = sttc_pkg::READ_UNMAPPED;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= 8'h00;
        end else begin
            rd_data_ff <= nxt_rd_data;
        end
    end

endmodule : sttc_status_regs

// ### hw/sttc_tick_counter.sv
`timescale 1ns/10ps
module sttc_tick_counter #(
    parameter int PRESCALE_W = 10,
    parameter int TICK_W = 8,
    parameter int PRESCALE_DIV = 1000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_rst,
    output logic [TICK_W-1:0] count_ff
);

    localparam logic [PRESCALE_W-1:0] PRE_LAST = PRESCALE_W'(PRESCALE_DIV - 1);

    logic [PRESCALE_W-1:0] prescale_ff;
    logic wrap;

    assign wrap = (prescale_ff == PRE_LAST);

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_ff <= '0;
        end else if (soft_rst || wrap) begin
            prescale_ff <= '0;
        end else begin
            prescale_ff <= prescale_ff + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Free-running count, wraps at all ones
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= '0;
        end else if (soft_rst) begin
            count_ff <= '0;
        end else if (wrap) begin
            count_ff <= count_ff + 1'b1;
        end
    end

endmodule : sttc_tick_counter

// ### tb/sttc_host_model.sv
`timescale 1ns/10ps
module sttc_host_model (
    input wire logic clk,
    input wire logic [7:0] rd_data_ff,
    output logic rd_en,
    output logic [7:0] rd_addr
);
    initial begin
        rd_en = 1'b0;
        rd_addr = 8'hff;
    end

    // Reads only, there is no write path; idle address is scrambled
    task automatic read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk);
        rd_en <= 1'b1;
        rd_addr <= addr;
        @(posedge clk);
        rd_en <= 1'b0;
        rd_addr <= ~addr;
        @(negedge clk);
        data = rd_data_ff;
    endtask : read
endmodule : sttc_host_model

// ### tb/sttc_status_regs_assertions.sv
`timescale 1ns/10ps
module sttc_status_regs_chk #(
    parameter int SUPPLY_RECOVERY_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_rst,
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    input wire logic selftest_incomplete,
    input wire logic common_mode_error,
    input wire logic selftest_error,
    input wire logic user_prog_active,
    input wire logic test_enter,
    input wire logic test_exit,
    input wire logic data_valid,
    input wire logic supply_undervoltage_mon,
    input wire logic analog_regulator_mon,
    input wire logic digital_regulator_mon,
    input wire logic nvm_regulator_mon,
    input wire logic continuity_mon,
    input wire logic supply_report_disable,
    input wire logic [7:0] rd_data_ff,
    input wire logic [7:0] summary_status_ff
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    logic any_mon;
    logic dsp_any;
    logic [15:0] quiet_cnt_ff;
    assign any_mon = supply_undervoltage_mon | analog_regulator_mon | digital_regulator_mon | nvm_regulator_mon
        | continuity_mon;
    assign dsp_any = selftest_incomplete | common_mode_error | selftest_error;

    // Cycles since any supply monitor was last high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            quiet_cnt_ff <= 16'h0000;
        end else if (any_mon || soft_rst) begin
            quiet_cnt_ff <= 16'h0000;
        end else if (quiet_cnt_ff != 16'hffff) begin
            quiet_cnt_ff <= quiet_cnt_ff + 16'h0001;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_dsp_or_flag: assert property ($past(rst_n) |-> summary_status_ff[7] == $past(dsp_any))
        else $error("dsp error flag does not follow its sources");
    a_mem_live_flag: assert property (user_prog_active && !soft_rst |=> ##1 summary_status_ff[4])
        else $error("memory flag missing while programming");
    a_supply_set_flag: assert property ((any_mon && !supply_report_disable && !soft_rst)
        ##1 (!supply_report_disable && !soft_rst) |=> summary_status_ff[3])
        else $error("supply flag not set by monitor");
    a_supply_hold_time: assert property ($fell(any_mon) && summary_status_ff[3]
        ##1 (!soft_rst && !supply_report_disable)[*8] |=> summary_status_ff[3])
        else $error("supply flag cleared before recovery interval");
    a_supply_clear_bound: assert property (quiet_cnt_ff == 16'(SUPPLY_RECOVERY_CYCLES + 4)
        |-> !summary_status_ff[3])
        else $error("supply flag still set after recovery interval");
    a_test_rise_cause: assert property ($rose(summary_status_ff[2]) |-> $past(test_enter, 2))
        else $error("test flag set without entry");
    a_test_fall_cause: assert property ($fell(summary_status_ff[2]) |-> $past(test_exit, 2))
        else $error("test flag cleared without exit");
    a_read_clears_reset: assert property ((rd_en && rd_addr == 8'h01 && !soft_rst) ##1 !soft_rst
        |=> !summary_status_ff[1])
        else $error("reset flag not cleared by summary read");
    a_soft_sets_flags: assert property (soft_rst |=> ##1 summary_status_ff[1:0] == 2'b11)
        else $error("soft reset did not set reset and init flags");
    a_init_clear_valid: assert property (data_valid && !soft_rst ##1 !soft_rst |=> !summary_status_ff[0])
        else $error("init flag not cleared by valid data");
    a_unmapped_zero: assert property (rd_en && rd_addr > 8'h03 |=> rd_data_ff == 8'h00)
        else $error("unmapped read returned nonzero");
endmodule : sttc_status_regs_chk

bind sttc_status_regs sttc_status_regs_chk #(.SUPPLY_RECOVERY_CYCLES(SUPPLY_RECOVERY_CYCLES)) chk (.*);

// ### tb/sttc_status_regs_tb.sv
`timescale 1ns/10ps
module sttc_status_regs_tb;
    localparam int REC = 20;
    localparam logic [19:0] SOFT = 20'h00001;
    localparam logic [19:0] SREP = 20'h00002;
    localparam logic [19:0] TEN = 20'h00004;
    localparam logic [19:0] TEX = 20'h00008;
    localparam logic [19:0] DV = 20'h00010;
    localparam logic [19:0] COMM = 20'h00020;
    localparam logic [19:0] DIS = 20'h80000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [19:0] src = 20'h00000;
    logic rd_en;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic [7:0] summary_out;
    logic [7:0] mmask [4] = '{8'h80, 8'h40, 8'h20, 8'h04};
    logic [7:0] smask [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h80};
    int n_fail = 0;
    int comparisons = 0;

    always #50 clk = ~clk;

    sttc_status_regs #(.SUPPLY_RECOVERY_CYCLES(REC)) dut (
        .clk(clk), .rst_n(rst_n), .soft_rst(src[0]), .rd_en(rd_en), .rd_addr(rd_addr),
        .status_reported(src[1]), .test_enter(src[2]), .test_exit(src[3]), .data_valid(src[4]),
        .communication_error(src[5]), .selftest_incomplete(src[6]), .common_mode_error(src[7]),
        .selftest_error(src[8]), .factory_nvm_error_evt(src[9]), .user_nvm_error_evt(src[10]),
        .user_reg_check_error_evt(src[11]), .temperature_error_evt(src[12]), .user_prog_active(src[13]),
        .continuity_mon(src[14]), .nvm_regulator_mon(src[15]), .digital_regulator_mon(src[16]),
        .analog_regulator_mon(src[17]), .supply_undervoltage_mon(src[18]), .supply_report_disable(src[19]),
        .rd_data_ff(rd_data), .summary_status_ff(summary_out)
    );

    sttc_host_model host (.clk(clk), .rd_data_ff(rd_data), .rd_en(rd_en), .rd_addr(rd_addr));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step

    task automatic pulse(input logic [19:0] m);
        @(posedge clk);
        src <= src | m;
        @(posedge clk);
        src <= src & ~m;
    endtask : pulse

    task automatic level(input logic [19:0] m, input logic v);
        @(posedge clk);
        src <= v ? (src | m) : (src & ~m);
    endtask : level

    task automatic check(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        step(3);
        host.read(a, d);
        comparisons++;
        if (d !== exp) begin
            n_fail++;
            $display("Error at %0t: addr %h read %h expected %h", $time, a, d, exp);
        end
    endtask : check

    task automatic check_sum(input logic [7:0] exp);
        @(negedge clk);
        comparisons++;
        if (summary_out !== exp) begin
            n_fail++;
            $display("Error at %0t: summary %h expected %h", $time, summary_out, exp);
        end
    endtask : check_sum

    task automatic end_of_test;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        step(2);
        rst_n <= 1'b1;
        step(1);
        check_sum(8'h03);
        check(8'h01, 8'h03);
        check(8'h01, 8'h01);
        pulse(DV);
        check(8'h01, 8'h00);
        check(8'h00, 8'h00);
        for (int k = 1; k <= 3; k++) begin
            step(1000);
            check(8'h00, 8'(k));
        end
        for (int i = 0; i < 3; i++) begin
            level(20'h00040 << i, 1'b1);
            check(8'h01, 8'h80);
            check_sum(8'h80);
            level(20'h00040 << i, 1'b0);
            check(8'h01, 8'h00);
        end
        level(COMM, 1'b1);
        check(8'h01, 8'h20);
        level(COMM, 1'b0);
        check(8'h01, 8'h00);
        for (int i = 0; i < 4; i++) begin
            pulse(20'h00200 << i);
            check(8'h01, 8'h10);
            check(8'h03, mmask[i]);
            check(8'h03, 8'h00);
            check(8'h01, 8'h00);
        end
        pulse(20'h00200);
        pulse(SREP);
        check(8'h03, 8'h00);
        level(20'h02000, 1'b1);
        check(8'h03, 8'h10);
        check(8'h01, 8'h10);
        level(20'h02000, 1'b0);
        check(8'h03, 8'h00);
        for (int i = 0; i < 5; i++) begin
            level(20'h04000 << i, 1'b1);
            step(2);
            level(20'h04000 << i, 1'b0);
            check(8'h02, smask[i]);
            check(8'h01, 8'h08);
            check_sum(8'h08);
            step(REC + 5);
            check(8'h02, 8'h00);
            check(8'h01, 8'h00);
        end
        level(DIS, 1'b1);
        level(20'h40000, 1'b1);
        check(8'h02, 8'h00);
        level(20'h40000, 1'b0);
        step(REC + 5);
        level(DIS, 1'b0);
        check(8'h02, 8'h00);
        pulse(TEN);
        check(8'h01, 8'h04);
        pulse(SOFT);
        check(8'h02, 8'h00);
        pulse(SREP);
        check(8'h01, 8'h05);
        pulse(DV);
        check(8'h01, 8'h04);
        pulse(TEX);
        check(8'h01, 8'h00);
        check(8'h10, 8'h00);
        check(8'hff, 8'h00);
        @(posedge clk);
        rst_n <= 1'b0;
        step(2);
        rst_n <= 1'b1;
        step(1);
        check_sum(8'h03);
        check(8'h01, 8'h03);
        check(8'h00, 8'h00);
        end_of_test();
    end
endmodule : sttc_status_regs_tb
